/* File: dtp_pkg.sv */
// Purpose: constants shared by the dual 8-bit timer / pwm / cascade block
// Assumes: one system clock; all control bits arrive as plain levels
// Notes: mode control bit positions double as pwm and interval controls

package dtp_pkg;

    // ************************************************************
    // mode control field positions
    // ************************************************************
    localparam int MC_ENABLE = 7;
    localparam int MC_PWM = 6;
    localparam int MC_CASCADE = 4;
    localparam int MC_LEVEL_SET = 3;
    localparam int MC_LEVEL_RESET = 2;
    // in pwm mode this is the inactive level, otherwise the toggle enable
    localparam int MC_LEVEL_TOGGLE = 1;
    localparam int MC_OUT_ENABLE = 0;

    // ************************************************************
    // clock select codes
    // ************************************************************
    localparam logic [7:0] CS_EDGE_FALL = 8'h00;
    localparam logic [7:0] CS_EDGE_RISE = 8'h01;
    // codes from this one up divide sys_clk by 2^(code - CS_DIV_BASE), at most 2^DIV_LOG_MAX
    localparam logic [7:0] CS_DIV_BASE = 8'h02;
    localparam int PRESCALE_W = 16;
    localparam logic [4:0] DIV_LOG_MAX = 5'd15;

    // ************************************************************
    // reset values and counter limits
    // ************************************************************
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hff;
    localparam logic [7:0] CMP_ZERO = 8'h00;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 16'h0000;
    localparam int SYNC_STAGES = 2;

endpackage

/* File: dtp_timer.sv */
// Purpose: two 8-bit timer/event counters with pwm and 16-bit cascade
// Assumes: control inputs come from sys_clk logic; event inputs are pins
// Notes: count clock is a one-cycle tick derived from sys_clk or an edge

`timescale 1ns/10ps

// Function
// - pwm mode chosen by mode bits; active level bit picks polarity
// - after enable in pwm, output stays inactive until first overflow
// - each overflow drives active level until counter equals compare
// - compare match drives inactive level until next overflow, repeating
// - clearing enable in pwm stops counting and forces inactive output
// - pwm period is 256 count clocks, active width is compare value
// - high channel cascade bit joins both into a 16-bit counter
// - low compare is low byte, high compare is high byte
// - in cascade only the low clock select picks count clock or edge
// - 16-bit interval match raises low irq and clears counter
// - event mode counts falling edge with code 00, rising with 01
// - event mode irq after N+1 edges, then counter clears
// - 16-bit square wave match toggles low flip-flop, irq, clear
// - level set/reset pick initial flip-flop state; toggle and output on
// - first match may be up to one count clock early, never late
// - pwm bit selects pwm; output enable gates signal onto the pin
module dtp_timer (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] low_clock_select,
    input wire logic [7:0] high_clock_select,
    input wire logic [7:0] low_mode_control,
    input wire logic [7:0] high_mode_control,
    input wire logic [7:0] low_compare,
    input wire logic [7:0] high_compare,
    input wire logic low_event_in,
    input wire logic high_event_in,
    output logic low_timer_out,
    output logic high_timer_out,
    output logic low_match_irq,
    output logic high_match_irq,
    output logic [7:0] low_counter,
    output logic [7:0] high_counter
);
    import dtp_pkg::*;

    // ************************************************************
    // count clock selection
    // ************************************************************
    function automatic logic sel_tick(input logic [7:0] sel,
                                      input logic [PRESCALE_W-1:0] pre,
                                      input logic fall,
                                      input logic rise);
        logic [7:0] k;
        logic [4:0] lg;
        logic [PRESCALE_W-1:0] mask;
        k = 8'h00;
        lg = 5'd0;
        mask = '0;
        if (sel == CS_EDGE_FALL) begin
            sel_tick = fall;
        end else if (sel == CS_EDGE_RISE) begin
            sel_tick = rise;
        end else begin
            k = sel - CS_DIV_BASE;
            lg = (k > {3'b000, DIV_LOG_MAX}) ? DIV_LOG_MAX : k[4:0];
            mask = PRESCALE_W'((32'h1 << lg) - 32'h1);
            sel_tick = ((pre & mask) == mask);
        end
    endfunction

    logic [PRESCALE_W-1:0] pre_reg;
    logic [PRESCALE_W-1:0] pre_next;

    // free-running prescaler: a start is not aligned to it
    assign pre_next = pre_reg + PRESCALE_W'(1);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pre_reg <= PRESCALE_RST;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // ************************************************************
    // event pin synchronisers and edge detect
    // ************************************************************
    logic [1:0] ev_pin;
    logic [1:0] ev_meta_reg;
    logic [1:0] ev_sync_reg;
    logic [1:0] ev_last_reg;
    logic [1:0] ev_fall;
    logic [1:0] ev_rise;

    assign ev_pin = {high_event_in, low_event_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ev
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    ev_meta_reg[gi] <= 1'b0;
                    ev_sync_reg[gi] <= 1'b0;
                    ev_last_reg[gi] <= 1'b0;
                end else begin
                    ev_meta_reg[gi] <= ev_pin[gi];
                    ev_sync_reg[gi] <= ev_meta_reg[gi];
                    ev_last_reg[gi] <= ev_sync_reg[gi];
                end
            end
            assign ev_fall[gi] = ev_last_reg[gi] & ~ev_sync_reg[gi];
            assign ev_rise[gi] = ~ev_last_reg[gi] & ev_sync_reg[gi];
        end
    endgenerate

    // ************************************************************
    // mode decode
    // ************************************************************
    logic cascade;
    logic en_lo;
    logic en_hi;
    logic pwm_lo;
    logic pwm_hi;
    logic tick_lo;
    logic tick_hi;

    assign cascade = high_mode_control[MC_CASCADE];
    assign en_lo = low_mode_control[MC_ENABLE];
    assign en_hi = high_mode_control[MC_ENABLE];
    // once the channels are joined pwm mode is off; the low pwm bit only blocks the flip-flop toggle
    assign pwm_lo = low_mode_control[MC_PWM] & ~cascade;
    assign pwm_hi = high_mode_control[MC_PWM] & ~cascade;

    assign tick_lo = sel_tick(low_clock_select, pre_reg, ev_fall[0], ev_rise[0]);
    // high clock select is ignored while cascaded
    assign tick_hi = cascade ? tick_lo
                   : sel_tick(high_clock_select, pre_reg, ev_fall[1], ev_rise[1]);

    // ************************************************************
    // counters and match
    // ************************************************************
    logic [7:0] cnt_lo_reg;
    logic [7:0] cnt_lo_next;
    logic [7:0] cnt_hi_reg;
    logic [7:0] cnt_hi_next;
    logic match_lo;
    logic match_hi;
    logic wide_match;
    logic clr_lo;
    logic clr_hi;
    logic lo_roll;
    logic run_wide;

    assign run_wide = cascade & en_lo & en_hi;
    assign wide_match = ({cnt_hi_reg, cnt_lo_reg} == {high_compare, low_compare});
    assign match_lo = cascade ? wide_match : (cnt_lo_reg == low_compare);
    assign match_hi = cnt_hi_reg == high_compare;
    // a match clears on the next count clock, so the period is N+1
    assign clr_lo = tick_lo & match_lo & ~pwm_lo;
    assign clr_hi = tick_hi & match_hi & ~pwm_hi;
    assign lo_roll = tick_lo & (cnt_lo_reg == COUNT_TOP);

    always_comb begin
        cnt_lo_next = cnt_lo_reg;
        if (!en_lo) begin
            cnt_lo_next = COUNT_RST;
        end else if (cascade & ~en_hi) begin
            cnt_lo_next = cnt_lo_reg;
        end else if (clr_lo) begin
            cnt_lo_next = COUNT_RST;
        end else if (tick_lo) begin
            // pwm wraps at 256 count clocks
            cnt_lo_next = cnt_lo_reg + 8'h01;
        end
    end

    always_comb begin
        cnt_hi_next = cnt_hi_reg;
        if (!en_hi) begin
            cnt_hi_next = COUNT_RST;
        end else if (cascade) begin
            if (run_wide & clr_lo) begin
                cnt_hi_next = COUNT_RST;
            end else if (run_wide & lo_roll) begin
                cnt_hi_next = cnt_hi_reg + 8'h01;
            end
        end else if (clr_hi) begin
            cnt_hi_next = COUNT_RST;
        end else if (tick_hi) begin
            cnt_hi_next = cnt_hi_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_lo_reg <= COUNT_RST;
            cnt_hi_reg <= COUNT_RST;
        end else begin
            cnt_lo_reg <= cnt_lo_next;
            cnt_hi_reg <= cnt_hi_next;
        end
    end

    // ************************************************************
    // pwm active phase
    // ************************************************************
    logic [1:0] act_reg;
    logic [1:0] act_next;
    logic [1:0] pwm_on;
    logic [1:0] ptick;
    logic [7:0] pcnt [2];
    logic [7:0] pcmp [2];

    assign pwm_on = {pwm_hi & en_hi, pwm_lo & en_lo};
    assign ptick = {tick_hi, tick_lo};
    assign pcnt[0] = cnt_lo_reg;
    assign pcnt[1] = cnt_hi_reg;
    assign pcmp[0] = low_compare;
    assign pcmp[1] = high_compare;

    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pwm
            always_comb begin
                act_next[gi] = act_reg[gi];
                if (!pwm_on[gi]) begin
                    act_next[gi] = 1'b0;
                end else if (ptick[gi] & (pcnt[gi] == COUNT_TOP)) begin
                    // overflow opens the active phase; zero width never opens
                    act_next[gi] = (pcmp[gi] != CMP_ZERO);
                end else if (ptick[gi] & (pcnt[gi] + 8'h01 == pcmp[gi])) begin
                    act_next[gi] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            act_reg <= 2'b00;
        end else begin
            act_reg <= act_next;
        end
    end

    // ************************************************************
    // timer output flip-flops (interval and square wave)
    // ************************************************************
    logic [1:0] ff_reg;
    logic [1:0] ff_next;
    logic [7:0] mc [2];
    logic [1:0] en_ch;
    logic [1:0] tgl;

    assign mc[0] = low_mode_control;
    assign mc[1] = high_mode_control;
    assign en_ch = {en_hi, en_lo};
    // a held cascade counter must not toggle the pin, same gating as the irq
    assign tgl = {clr_hi & ~cascade, clr_lo & (~cascade | en_hi)};

    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ff
            always_comb begin
                ff_next[gi] = ff_reg[gi];
                if (!en_ch[gi]) begin
                    // preset only while stopped, so a running wave is untouched
                    if (mc[gi][MC_LEVEL_SET] & ~mc[gi][MC_LEVEL_RESET]) begin
                        ff_next[gi] = 1'b1;
                    end else if (~mc[gi][MC_LEVEL_SET] & mc[gi][MC_LEVEL_RESET]) begin
                        ff_next[gi] = 1'b0;
                    end
                end else if (tgl[gi] & mc[gi][MC_LEVEL_TOGGLE] & ~mc[gi][MC_PWM]) begin
                    ff_next[gi] = ~ff_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ff_reg <= 2'b00;
        end else begin
            ff_reg <= ff_next;
        end
    end

    // ************************************************************
    // pins and interrupts
    // ************************************************************
    logic out_lo_next;
    logic out_hi_next;
    logic irq_lo_next;
    logic irq_hi_next;

    // inactive level equals the active level select bit
    assign out_lo_next = low_mode_control[MC_OUT_ENABLE]
                       & (pwm_lo ? (act_next[0] ^ low_mode_control[MC_LEVEL_TOGGLE])
                                 : ff_next[0]);
    // high pin is idle while cascaded
    assign out_hi_next = ~cascade & high_mode_control[MC_OUT_ENABLE]
                       & (pwm_hi ? (act_next[1] ^ high_mode_control[MC_LEVEL_TOGGLE])
                                 : ff_next[1]);
    assign irq_lo_next = clr_lo & en_lo & (~cascade | en_hi);
    assign irq_hi_next = clr_hi & en_hi & ~cascade;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            low_timer_out <= 1'b0;
            high_timer_out <= 1'b0;
            low_match_irq <= 1'b0;
            high_match_irq <= 1'b0;
            low_counter <= COUNT_RST;
            high_counter <= COUNT_RST;
        end else begin
            low_timer_out <= out_lo_next;
            high_timer_out <= out_hi_next;
            low_match_irq <= irq_lo_next;
            high_match_irq <= irq_hi_next;
            low_counter <= cnt_lo_next;
            high_counter <= cnt_hi_next;
        end
    end

endmodule

/* File: dtp_timer_chk.sv */
// Purpose: port-level assertions for the dual timer block
// Assumes: pwm timing checks run with a count tick on every sys_clk cycle
// Notes: pwm period and width are measured by small helper counters
`timescale 1ns/10ps
module dtp_timer_chk
    import dtp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] low_clock_select,
    input wire logic [7:0] low_mode_control,
    input wire logic [7:0] high_mode_control,
    input wire logic [7:0] low_compare,
    input wire logic [7:0] high_compare,
    input wire logic low_timer_out,
    input wire logic high_timer_out,
    input wire logic low_match_irq,
    input wire logic high_match_irq,
    input wire logic [7:0] low_counter,
    input wire logic [7:0] high_counter
);
    logic q_reg, armed_reg;
    logic [8:0] per_reg, wid_reg;
    logic [7:0] cmp_reg;
    wire rise = low_timer_out & ~q_reg;
    wire fall = ~low_timer_out & q_reg;
    wire casc = high_mode_control[MC_CASCADE];
    wire lpwm = low_mode_control[MC_PWM];
    wire len = low_mode_control[MC_ENABLE];
    wire pwm_cfg = low_mode_control == 8'hc1 && low_clock_select == CS_DIV_BASE;
    wire both_on = len && high_mode_control[MC_ENABLE];
    // measurement is only trusted from one rise to the next with no config change
    always_ff @(posedge sys_clk) begin
        q_reg <= low_timer_out;
        cmp_reg <= low_compare;
        per_reg <= rise ? 9'h001 : per_reg + 9'h001;
        wid_reg <= rise ? 9'h001 : wid_reg + 9'(low_timer_out);
        armed_reg <= rstn && pwm_cfg && cmp_reg == low_compare && (armed_reg || rise);
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence pwm_idle_s;
        low_timer_out == (low_mode_control[MC_OUT_ENABLE] & low_mode_control[MC_LEVEL_TOGGLE]);
    endsequence
    sequence wide_match_s;
        casc && !lpwm && both_on && low_clock_select == CS_DIV_BASE
            && {high_counter, low_counter} == {high_compare, low_compare};
    endsequence
    chk_pwm_start_idle: assert property ($rose(len) && lpwm |-> ##1 pwm_idle_s [*8])
        else $error("pwm output active right after enable");
    chk_pwm_stop_idle: assert property (!len && lpwm && $stable(low_mode_control) |-> pwm_idle_s)
        else $error("stopped pwm output not at inactive level");
    chk_pwm_oe_gate: assert property (lpwm && !low_mode_control[MC_OUT_ENABLE]
        && $stable(low_mode_control) |-> !low_timer_out)
        else $error("pwm output reached pin with output disabled");
    chk_pwm_period_len: assert property (armed_reg && rise |-> per_reg == 9'h100)
        else $error("pwm period not 256 ticks");
    chk_pwm_active_width: assert property (armed_reg && fall |-> wid_reg == {1'b0, low_compare})
        else $error("pwm active width differs from compare");
    chk_casc_high_quiet: assert property (casc && $past(casc) |-> !high_match_irq && !high_timer_out)
        else $error("high channel active while cascaded");
    chk_irq_clears_count: assert property (low_match_irq && !lpwm && casc
        |-> {high_counter, low_counter} == 16'h0000)
        else $error("wide counter not cleared with interrupt");
    chk_wide_match_irq: assert property (wide_match_s
        and $stable(low_mode_control) and $stable(high_mode_control) |=> low_match_irq)
        else $error("wide compare match gave no interrupt");
    chk_square_toggle: assert property (low_match_irq && casc && !lpwm
        && $stable(low_mode_control)
        && low_mode_control[MC_LEVEL_TOGGLE:MC_OUT_ENABLE] == 2'b11
        |-> low_timer_out != $past(low_timer_out))
        else $error("square wave did not toggle on match");
endmodule
bind dtp_timer dtp_timer_chk chk_u (.sys_clk(sys_clk), .rstn(rstn),
    .low_clock_select(low_clock_select), .low_mode_control(low_mode_control),
    .high_mode_control(high_mode_control), .low_compare(low_compare),
    .high_compare(high_compare), .low_timer_out(low_timer_out),
    .high_timer_out(high_timer_out), .low_match_irq(low_match_irq),
    .high_match_irq(high_match_irq), .low_counter(low_counter), .high_counter(high_counter));

/* File: tb_top.sv */
// Purpose: self-checking bench for the dual timer block
// Assumes: cascade interval rows first, then square wave, events and pwm
// Notes: the first interval after a start is discarded because of start jitter
`timescale 1ns/10ps
module tb_top;
    import dtp_pkg::*;
    logic sys_clk, rstn, low_event_in, high_event_in, low_timer_out, high_timer_out;
    logic [7:0] low_clock_select, high_clock_select, low_mode_control, high_mode_control;
    logic [7:0] low_compare, high_compare, low_counter, high_counter;
    logic low_match_irq, high_match_irq;
    int fail_count = 0, n_compared = 0, irq_cnt = 0, t, c, p;
    typedef struct {logic [15:0] n; logic [7:0] cs; int per;} dtp_row_t;
    dtp_row_t rows [4] = '{'{16'h0000, 8'h02, 1}, '{16'h0002, 8'h02, 3},
        '{16'h0103, 8'h02, 260}, '{16'h0005, 8'h03, 12}};
    dtp_timer dut_u (.sys_clk(sys_clk), .rstn(rstn), .low_clock_select(low_clock_select),
        .high_clock_select(high_clock_select), .low_mode_control(low_mode_control),
        .high_mode_control(high_mode_control), .low_compare(low_compare),
        .high_compare(high_compare), .low_event_in(low_event_in), .high_event_in(high_event_in),
        .low_timer_out(low_timer_out), .high_timer_out(high_timer_out),
        .low_match_irq(low_match_irq), .high_match_irq(high_match_irq),
        .low_counter(low_counter), .high_counter(high_counter));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (low_match_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    task automatic stop_test;
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_irq(output int cyc);
        int c0;
        c0 = irq_cnt;
        cyc = 0;
        while (irq_cnt == c0) begin
            @(posedge sys_clk);
            cyc++;
            if (cyc > 3000) begin
                fail_count++;
                $display("[FAIL] %0t no interrupt", $time);
                stop_test();
            end
        end
    endtask
    // compare and clock select only change while the low channel is stopped
    task automatic casc_run(input logic [15:0] n, input logic [7:0] cs, input logic [7:0] lmc);
        @(posedge sys_clk);
        low_mode_control <= lmc & 8'h7f;
        @(posedge sys_clk);
        high_mode_control <= 8'h10;
        {high_compare, low_compare} <= n;
        low_clock_select <= cs;
        @(posedge sys_clk);
        high_mode_control <= 8'h90;
        @(posedge sys_clk);
        low_mode_control <= lmc;
    endtask
    task automatic pwm_run(input logic [7:0] mc, input logic [7:0] n);
        int a;
        @(posedge sys_clk);
        low_mode_control <= mc & 8'h7f;
        low_compare <= n;
        low_clock_select <= CS_DIV_BASE;
        @(posedge sys_clk);
        low_mode_control <= mc;
        a = 0;
        // first period is inactive, so measure a later full period
        repeat (260) @(posedge sys_clk);
        for (int i = 0; i < 256; i++) begin
            @(posedge sys_clk);
            a += (low_timer_out !== (mc[0] & mc[1]));
        end
        chk(16'(a), mc[0] ? {8'h00, n} : 16'h0000);
        @(posedge sys_clk);
        low_mode_control <= mc & 8'h7f;
        repeat (2) @(posedge sys_clk);
        chk({15'h0, low_timer_out}, {15'h0, mc[0] & mc[1]});
    endtask
    initial begin
        rstn = 1'b0;
        low_event_in = 1'b0;
        high_event_in = 1'b0;
        low_clock_select = 8'h02;
        high_clock_select = 8'h05;
        low_mode_control = 8'h00;
        high_mode_control = 8'h00;
        low_compare = 8'h00;
        high_compare = 8'h00;
        repeat (5) @(posedge sys_clk);
        chk({low_counter, high_counter}, 16'h0000);
        chk({14'h0, low_timer_out, low_match_irq}, 16'h0000);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            casc_run(rows[i].n, rows[i].cs, 8'h80);
            wait_irq(t);
            wait_irq(t);
            chk(16'(t), 16'(rows[i].per));
        end
        casc_run(16'h0002, 8'h02, 8'h0b);
        repeat (3) @(posedge sys_clk);
        chk({15'h0, low_timer_out}, 16'h0001);
        casc_run(16'h0002, 8'h02, 8'h87);
        chk({15'h0, low_timer_out}, 16'h0000);
        wait_irq(t);
        chk({15'h0, low_timer_out}, 16'h0001);
        wait_irq(t);
        chk({15'h0, low_timer_out}, 16'h0000);
        chk({14'h0, high_timer_out, high_match_irq}, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            casc_run(16'h0003, 8'(k), 8'h80);
            c = irq_cnt;
            p = 0;
            while (irq_cnt == c && p < 8) begin
                @(posedge sys_clk);
                low_event_in <= 1'b1;
                repeat (6) @(posedge sys_clk);
                low_event_in <= 1'b0;
                repeat (6) @(posedge sys_clk);
                p++;
            end
            chk(16'(p), 16'h0004);
        end
        @(posedge sys_clk);
        low_mode_control <= 8'h00;
        @(posedge sys_clk);
        high_mode_control <= 8'h00;
        pwm_run(8'hc1, 8'h40);
        pwm_run(8'hc3, 8'hff);
        pwm_run(8'hc1, 8'h00);
        pwm_run(8'hc0, 8'h20);
        casc_run(16'hffff, 8'h02, 8'h80);
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({low_counter, high_counter}, 16'h0000);
        chk({12'h0, low_timer_out, high_timer_out, low_match_irq, high_match_irq}, 16'h0000);
        rstn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        stop_test();
    end
endmodule
